// >>> rtl/asc_pkg.sv
// How it works
// R1: status register is eight bits, read-only
// R2: host sends read command, address 0,0
// R3: status shifts out bit seven first
// R4: status resets zero; bits 6,5,4,2 zero
// R5: fresh flag sets when result stored
// R6: fresh flag clears on data read, pre-update
// R7: clamp flag sets with fresh on clamp
// R8: clamp flag clears on conversion start
// R9: status bit one mirrors standby
// R10: status bit zero shows synthesiser lock
// R11: host discards results while unlocked
// R12: config register 24 bits, resets 000007
// R13: config shifts most significant bit first
// R14: config write acts at once, no restart
// R15: host waits three outputs after source change
// R16: bit 23 closes second ground switch
// R17: bit 22 closes first ground switch
// R18: standby forces both ground switches open
// R19: source three field routes to pins
// R20: command byte: enable, read, address bits
// R21: after access, wait for next command
// R22: 32 ones on data input resets
// R23: reserved routing code means source off
package asc_pkg;

   // ==========================================================
   // register addresses carried in the command byte
   // ==========================================================
   localparam logic [1:0] ADDR_STATUS = 2'h0;
   localparam logic [1:0] ADDR_CONFIG = 2'h1;
   localparam logic [1:0] ADDR_FILTER = 2'h2;
   localparam logic [1:0] ADDR_DATA = 2'h3;

   // ==========================================================
   // command byte fields
   // ==========================================================
   localparam int CMD_RD_BIT = 6; // read when one
   localparam int CMD_LOW_POWER_STATE_FLAG_BIT = 5; // standby request
   localparam logic [4:0] CMD_LAST = 5'h07; // index of the final bit

   // ==========================================================
   // status register layout
   // ==========================================================
   localparam int SR_FRESH = 7;
   localparam int SR_CLAMP = 3;
   localparam int SR_LOW_POWER_STATE_FLAG = 1;
   localparam int SR_LOCK = 0;
   localparam logic [7:0] SR_RESET = 8'h00;
   localparam logic [7:0] SR_UNUSED = 8'h74; // bits 6,5,4,2

   // ==========================================================
   // configuration register layout
   // ==========================================================
   localparam int CFG_W = 24;
   localparam logic [23:0] CFG_RESET = 24'h000007;
   localparam int CFG_SW2 = 23;
   localparam int CFG_SW1 = 22;
   localparam int CFG_SRC3_HI = 21;
   localparam int CFG_SRC3_LO = 20;

   // source routing codes; the remaining code is reserved
   localparam logic [1:0] ROUTE_PIN_ONE = 2'h1;
   localparam logic [1:0] ROUTE_PIN_TWO = 2'h2;

   // ==========================================================
   // transfer lengths in serial bits
   // ==========================================================
   localparam logic [4:0] LEN_STATUS = 5'h08;
   localparam logic [4:0] LEN_CONFIG = 5'h18;
   localparam logic [4:0] LEN_FILTER = 5'h08;
   localparam int DATA_W = 16;
   localparam logic [4:0] LEN_LAST = 5'h01;

   // ones on the data input that force a reset
   localparam logic [5:0] RESYNC_ONES = 6'h20;

   // ==========================================================
   // serial engine phases
   // ==========================================================
   typedef enum logic [1:0] {
      PH_CMD = 2'b00,
      PH_WRITE = 2'b01,
      PH_READ = 2'b10
   } asc_phase_t;

endpackage : asc_pkg

// >>> rtl/asc_link_if.sv
// synchronised view of the serial pins, one cycle pulses for edges
interface asc_link_if;
   logic sclk_rise; // serial clock rose
   logic sclk_fall; // serial clock fell
   logic din_bit; // data input, aligned with the edge pulses
   logic cs_active; // chip select asserted
   logic lock_ok; // synthesiser lock, synchronised

   modport src (
      output sclk_rise, sclk_fall, din_bit, cs_active, lock_ok
   );
   modport sink (
      input sclk_rise, sclk_fall, din_bit, cs_active, lock_ok
   );
endinterface : asc_link_if

// >>> rtl/asc_link_sync.sv
// two-flop synchronisers for the pins and serial clock edge finder
module asc_link_sync (
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic sclk_in,
   input wire logic din_in,
   input wire logic cs_n_in,
   input wire logic pll_lock_in,
   asc_link_if.src link
);
   import asc_pkg::*;

   // ==========================================================
   // state
   // ==========================================================
   typedef struct packed {
      logic sclk_s1; // first stages feed only second stages
      logic sclk_s2;
      logic sclk_prev; // delayed copy for edge finding
      logic din_s1;
      logic din_s2;
      logic din_q; // aligned with the edge pulses
      logic csn_s1;
      logic csn_s2;
      logic cs_q;
      logic lock_s1;
      logic lock_s2;
      logic rise;
      logic fall;
   } asc_sync_t;

   // serial clock idles high, so reset it high to avoid a false edge
   localparam asc_sync_t SYNC_RESET = '{
      sclk_s1: 1'b1, sclk_s2: 1'b1, sclk_prev: 1'b1,
      csn_s1: 1'b1, csn_s2: 1'b1, default: 1'b0};

   asc_sync_t st_ff;
   asc_sync_t nxt_st;

   // ==========================================================
   // next state
   // ==========================================================
   always_comb begin
      nxt_st = st_ff;
      nxt_st.sclk_s1 = sclk_in;
      nxt_st.sclk_s2 = st_ff.sclk_s1;
      nxt_st.sclk_prev = st_ff.sclk_s2;
      nxt_st.din_s1 = din_in;
      nxt_st.din_s2 = st_ff.din_s1;
      nxt_st.din_q = st_ff.din_s2;
      nxt_st.csn_s1 = cs_n_in;
      nxt_st.csn_s2 = st_ff.csn_s1;
      nxt_st.cs_q = ~st_ff.csn_s2;
      nxt_st.lock_s1 = pll_lock_in;
      nxt_st.lock_s2 = st_ff.lock_s1;
      // edges come from settled stages only
      nxt_st.rise = st_ff.sclk_s2 & ~st_ff.sclk_prev;
      nxt_st.fall = ~st_ff.sclk_s2 & st_ff.sclk_prev;
   end

   // state register
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_ff <= SYNC_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign link.sclk_rise = st_ff.rise;
   assign link.sclk_fall = st_ff.fall;
   assign link.din_bit = st_ff.din_q;
   assign link.cs_active = st_ff.cs_q;
   assign link.lock_ok = st_ff.lock_s2;

endmodule : asc_link_sync

// >>> rtl/asc_regs_top.sv
// status and configuration registers behind the three-wire port
module asc_regs_top #(
   parameter int DATA_BITS = asc_pkg::DATA_W // conversion word width
) (
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic sclk_in, // serial clock pin
   input wire logic din_in, // serial data pin
   input wire logic cs_n_in, // chip select pin
   input wire logic pll_lock_in, // synthesiser lock, async
   input wire logic conv_result_load_in, // result stored, pulse
   input wire logic conv_result_clamped_in, // stored result clamped
   input wire logic result_update_soon_in, // next result is near
   input wire logic conv_start_in, // mode bits start conversion
   input wire logic [DATA_BITS-1:0] data_word_in, // conversion word
   output logic dout_out,
   output logic dout_oe_out,
   output logic standby_out,
   output logic switch_one_close_out,
   output logic switch_two_close_out,
   output logic src3_pin_one_out,
   output logic src3_pin_two_out,
   output logic [asc_pkg::CFG_W-1:0] front_end_setup_out
);
   import asc_pkg::*;

   // ==========================================================
   // elaboration checks
   // ==========================================================
   if (DATA_BITS < 1 || DATA_BITS > CFG_W) begin : g_bad_width
      $error("data width must be 1 to 24 bits");
   end

   // ==========================================================
   // state
   // ==========================================================
   typedef struct packed {
      asc_phase_t phase; // serial engine phase
      logic [4:0] bit_cnt; // bits taken or still to move
      logic [CFG_W-1:0] shreg; // shared shift register
      logic [1:0] addr; // register picked by the command
      logic [5:0] ones_cnt; // run of ones on the data input
      logic [CFG_W-1:0] setup; // configuration register
      logic fresh; // result-fresh flag
      logic clamp; // clamp fault flag
      logic low_power_state_flag; // low_power_state_flag
      logic dout;
      logic dout_oe;
      logic sw1;
      logic sw2;
      logic src_p1;
      logic src_p2;
   } asc_state_t;

   localparam asc_state_t ST_RESET = '{
      phase: PH_CMD, setup: CFG_RESET, default: '0};

   asc_link_if link ();

   asc_state_t st_ff;
   asc_state_t nxt_st;
   logic [7:0] status_word; // adc_state_flags as seen by a read
   logic [CFG_W-1:0] din_shift; // shift register with new bit in
   logic [7:0] cmd_byte; // command byte on its last bit
   logic data_read_done; // last bit of a data read went out
   logic resync; // long run of ones seen

   // ==========================================================
   // pin synchroniser
   // ==========================================================
   asc_link_sync u_sync (
      .sys_clk_in(sys_clk_in),
      .resetn_in(resetn_in),
      .sclk_in(sclk_in),
      .din_in(din_in),
      .cs_n_in(cs_n_in),
      .pll_lock_in(pll_lock_in),
      .link(link.src)
   );

   // ==========================================================
   // status word assembly
   // ==========================================================
   always_comb begin
      status_word = SR_RESET;
      // R1: status assembled, never stored
      // R4: unused bits stay zero
      status_word[SR_FRESH] = st_ff.fresh;
      status_word[SR_CLAMP] = st_ff.clamp;
      // R9: standby indication
      status_word[SR_LOW_POWER_STATE_FLAG] = st_ff.low_power_state_flag;
      // R10: lock indication
      status_word[SR_LOCK] = link.lock_ok;
   end

   // ==========================================================
   // serial engine, flags and outputs
   // ==========================================================
   always_comb begin
      nxt_st = st_ff;
      data_read_done = 1'b0;
      resync = 1'b0;
      din_shift = {st_ff.shreg[CFG_W-2:0], link.din_bit};
      cmd_byte = din_shift[7:0];
      nxt_st.dout_oe = link.cs_active;

      if (!link.cs_active) begin
         // deselect abandons any half-done access
         nxt_st.phase = PH_CMD;
         nxt_st.bit_cnt = '0;
      end else if (link.sclk_rise) begin
         // R22: count ones on every sampled bit
         if (link.din_bit) begin
            nxt_st.ones_cnt = st_ff.ones_cnt + 6'h01;
         end else begin
            nxt_st.ones_cnt = '0;
         end
         case (st_ff.phase)
            PH_CMD: begin
               // R20: a one in the enable slot is not taken
               if (st_ff.bit_cnt != '0 || !link.din_bit) begin
                  nxt_st.shreg = din_shift;
                  nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
                  if (st_ff.bit_cnt == CMD_LAST) begin
                     // R20: decode read flag and address
                     nxt_st.addr = cmd_byte[1:0];
                     nxt_st.low_power_state_flag = cmd_byte[CMD_LOW_POWER_STATE_FLAG_BIT];
                     nxt_st.phase = cmd_byte[CMD_RD_BIT] ?
                        PH_READ : PH_WRITE;
                     // length of the access that follows
                     if (cmd_byte[1:0] == ADDR_STATUS) begin
                        nxt_st.bit_cnt = LEN_STATUS;
                     end else if (cmd_byte[1:0] == ADDR_CONFIG) begin
                        nxt_st.bit_cnt = LEN_CONFIG;
                     end else if (cmd_byte[1:0] == ADDR_FILTER) begin
                        nxt_st.bit_cnt = LEN_FILTER;
                     end else begin
                        nxt_st.bit_cnt = 5'(DATA_BITS);
                     end
                     // R3: R13: load left aligned so msb leaves first
                     if (cmd_byte[1:0] == ADDR_STATUS) begin
                        nxt_st.shreg = {status_word, 16'h0000};
                     end else if (cmd_byte[1:0] == ADDR_CONFIG) begin
                        nxt_st.shreg = st_ff.setup;
                     end else if (cmd_byte[1:0] == ADDR_FILTER) begin
                        nxt_st.shreg = '0;
                     end else begin
                        nxt_st.shreg = CFG_W'(data_word_in) <<
                           (CFG_W - DATA_BITS);
                     end
                     // writing the command slot is only a command
                     if (!cmd_byte[CMD_RD_BIT] &&
                         cmd_byte[1:0] == ADDR_STATUS) begin
                        nxt_st.phase = PH_CMD;
                        nxt_st.bit_cnt = '0;
                     end
                  end
               end
            end
            PH_WRITE: begin
               nxt_st.shreg = din_shift;
               nxt_st.bit_cnt = st_ff.bit_cnt - 5'h01;
               if (st_ff.bit_cnt == LEN_LAST) begin
                  // R14: config takes effect at once; R1: status writes
                  // end at the command byte; filter and data writes are dropped here
                  if (st_ff.addr == ADDR_CONFIG) begin
                     nxt_st.setup = din_shift;
                  end
                  // R21: back to waiting for a command
                  nxt_st.phase = PH_CMD;
                  nxt_st.bit_cnt = '0;
               end
            end
            PH_READ: begin
               nxt_st.bit_cnt = st_ff.bit_cnt - 5'h01;
               if (st_ff.bit_cnt == LEN_LAST) begin
                  data_read_done = (st_ff.addr == ADDR_DATA);
                  // R21: back to waiting for a command
                  nxt_st.phase = PH_CMD;
                  nxt_st.bit_cnt = '0;
               end
            end
            default: begin
               nxt_st.phase = PH_CMD;
               nxt_st.bit_cnt = '0;
            end
         endcase
      end else if (link.sclk_fall && st_ff.phase == PH_READ) begin
         // R3: R13: next bit driven on the falling edge
         nxt_st.dout = st_ff.shreg[CFG_W-1];
         nxt_st.shreg = {st_ff.shreg[CFG_W-2:0], 1'b0};
      end

      // R6: clear on data read or ahead of an update
      if (data_read_done || result_update_soon_in) begin
         nxt_st.fresh = 1'b0;
      end
      // R8: conversion start clears the clamp flag
      if (conv_start_in) begin
         nxt_st.clamp = 1'b0;
      end
      // R5: a new result wins over a clear
      if (conv_result_load_in) begin
         nxt_st.fresh = 1'b1;
         // R7: clamp rises together with fresh
         if (conv_result_clamped_in) begin
            nxt_st.clamp = 1'b1;
         end
      end

      // R22: a long run of ones resets the part
      if (nxt_st.ones_cnt == RESYNC_ONES) begin
         resync = 1'b1;
         nxt_st = ST_RESET;
         nxt_st.dout_oe = link.cs_active;
      end

      // R16: R17: switches follow their bits, R18: open in standby
      nxt_st.sw2 = nxt_st.setup[CFG_SW2] & ~nxt_st.low_power_state_flag;
      nxt_st.sw1 = nxt_st.setup[CFG_SW1] & ~nxt_st.low_power_state_flag;
      // R19: R23: routing decode, reserved code routes nowhere
      nxt_st.src_p1 = nxt_st.setup[CFG_SRC3_HI:CFG_SRC3_LO] ==
         ROUTE_PIN_ONE;
      nxt_st.src_p2 = nxt_st.setup[CFG_SRC3_HI:CFG_SRC3_LO] ==
         ROUTE_PIN_TWO;
   end

   // state register; R4: R12: reset values
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_ff <= ST_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================
   // outputs, all straight from flip-flops
   // ==========================================================
   assign dout_out = st_ff.dout;
   assign dout_oe_out = st_ff.dout_oe;
   assign standby_out = st_ff.low_power_state_flag;
   assign switch_one_close_out = st_ff.sw1;
   assign switch_two_close_out = st_ff.sw2;
   assign src3_pin_one_out = st_ff.src_p1;
   assign src3_pin_two_out = st_ff.src_p2;
   assign front_end_setup_out = st_ff.setup;

   // ==========================================================
   // checks
   // ==========================================================
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);

   status_unused_a: assert property ( // R4
      (status_word & SR_UNUSED) == 8'h00)
      else $error("unused status bits not zero");

   fresh_cause_a: assert property ( // R5
      $rose(st_ff.fresh) |-> $past(conv_result_load_in))
      else $error("fresh flag rose without a result");

   fresh_clear_a: assert property ( // R6
      data_read_done && !conv_result_load_in && !resync
      |=> !st_ff.fresh)
      else $error("fresh flag kept after data read");

   clamp_pair_a: assert property ( // R7
      $rose(st_ff.clamp) |-> st_ff.fresh &&
      $past(conv_result_clamped_in))
      else $error("clamp flag rose alone");

   clamp_clear_a: assert property ( // R8
      conv_start_in && !conv_result_load_in |=> !st_ff.clamp)
      else $error("clamp flag survived conversion start");

   msb_first_a: assert property ( // R13
      link.cs_active && link.sclk_fall && st_ff.phase == PH_READ
      |=> st_ff.dout == $past(st_ff.shreg[CFG_W-1]))
      else $error("serial output not msb first");

   standby_open_a: assert property ( // R18
      st_ff.low_power_state_flag |-> !st_ff.sw1 && !st_ff.sw2)
      else $error("ground switch closed in standby");

   route_excl_a: assert property ( // R23
      st_ff.setup[CFG_SRC3_HI:CFG_SRC3_LO] == 2'h3
      |-> !st_ff.src_p1 && !st_ff.src_p2)
      else $error("reserved route drives a pin");

   resync_reset_a: assert property ( // R22
      resync |=> st_ff.phase == PH_CMD && st_ff.setup == CFG_RESET
      && !st_ff.fresh ##1 !st_ff.sw1)
      else $error("run of ones did not reset");

   cmd_return_a: assert property ( // R21
      st_ff.phase == PH_WRITE && st_ff.bit_cnt == LEN_LAST &&
      link.cs_active && link.sclk_rise |=> st_ff.phase == PH_CMD)
      else $error("engine did not return to command");

endmodule : asc_regs_top

// >>> dv/asc_host_model.sv
// host side of the three-wire port: frames commands and data bits
module asc_host_model (
   input wire logic sys_clk_in,
   input wire logic dout_in,
   output logic sclk_out,
   output logic din_out,
   output logic cs_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // timing: low half 12 system clocks, high half 13: 125 ns a bit
   // ==========================================================
   localparam int HALF = 12;
   // serial clock idles high and only moves inside frames
   initial begin
      sclk_out = 1'b1;
      din_out = 1'b0;
      cs_n_out = 1'b1;
   end
   // one half period of the serial clock
   task automatic half_wait();
      repeat (HALF) @(posedge sys_clk_in);
   endtask : half_wait
   // one bit: drive on the falling edge, sample just before rising
   task automatic bit_cycle(input logic b, output logic s);
      sclk_out <= 1'b0;
      din_out <= b;
      half_wait();
      s = dout_in;
      sclk_out <= 1'b1;
      repeat (HALF + 1) @(posedge sys_clk_in);
   endtask : bit_cycle
   // ==========================================================
   // framed access: command byte then n data bits, msb first
   // ==========================================================
   // command then data
   task automatic xfer(input logic [7:0] cmd, input int n,
                       input logic [31:0] wd, output logic [31:0] rd);
      logic s;
      rd = 32'h0;
      cs_n_out <= 1'b0;
      half_wait();
      for (int i = 7; i >= 0; i--) bit_cycle(cmd[i], s);
      for (int i = n - 1; i >= 0; i--) begin
         bit_cycle(wd[i], s);
         rd = {rd[30:0], s};
      end
      // data line flips after the frame so nothing relies on it
      cs_n_out <= 1'b1;
      din_out <= ~din_out;
      half_wait();
   endtask : xfer
   task automatic ones(input int n);
      logic s;
      cs_n_out <= 1'b0;
      half_wait();
      for (int i = 0; i < n; i++) bit_cycle(1'b1, s);
      cs_n_out <= 1'b1;
      din_out <= 1'b0;
      half_wait();
   endtask : ones
endmodule : asc_host_model

// >>> dv/tb_adc_status_config_regs.sv
// self-checking bench for the status and configuration registers
module tb_adc_status_config_regs;
   timeunit 1ns;
   timeprecision 1ps;
   import asc_pkg::*;
   // ==========================================================
   // design signals
   // ==========================================================
   logic sys_clk_in, resetn_in, sclk, din, cs_n, lock;
   logic ld, clamped, soon, start;
   logic [15:0] word;
   logic dout, dout_oe, low_power_state_flag, sw1, sw2, pin1, pin2;
   logic [CFG_W-1:0] setup;
   int n_errors = 0;
   int n_checks = 0;
   // reference model state, plain integers
   int m_fresh, m_clamp, m_low_power_state_flag, m_lock, m_cfg;
   logic [31:0] rd;
   int unsigned rnd;
   asc_regs_top #(.DATA_BITS(16)) i_asc_regs_top (
      .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .sclk_in(sclk),
      .din_in(din), .cs_n_in(cs_n), .pll_lock_in(lock),
      .conv_result_load_in(ld), .conv_result_clamped_in(clamped),
      .result_update_soon_in(soon), .conv_start_in(start),
      .data_word_in(word), .dout_out(dout), .dout_oe_out(dout_oe),
      .standby_out(low_power_state_flag), .switch_one_close_out(sw1),
      .switch_two_close_out(sw2), .src3_pin_one_out(pin1),
      .src3_pin_two_out(pin2), .front_end_setup_out(setup));
   asc_host_model i_asc_host_model (
      .sys_clk_in(sys_clk_in), .dout_in(dout), .sclk_out(sclk),
      .din_out(din), .cs_n_out(cs_n));
   // 200 MHz system clock
   initial begin
      sys_clk_in = 1'b0;
      forever #2.5 sys_clk_in = ~sys_clk_in;
   end
   // ==========================================================
   // checking and closing
   // ==========================================================
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : stop_test
   // expected status byte from the model
   function automatic logic [31:0] exp_st();
      return {24'h0, m_fresh[0], 3'h0, m_clamp[0], 1'b0, m_low_power_state_flag[0],
              m_lock[0]};
   endfunction : exp_st
   // access through the host; standby follows every command byte
   task automatic acc(input logic [7:0] cmd, input int n,
                      input logic [31:0] wd);
      m_low_power_state_flag = cmd[CMD_LOW_POWER_STATE_FLAG_BIT];
      i_asc_host_model.xfer(cmd, n, wd, rd);
      if (cmd == 8'h43) m_fresh = 0;
      if (cmd == 8'h01 || cmd == 8'h21) m_cfg = wd[23:0];
   endtask : acc
   // status read compared with the model
   task automatic rd_status(input logic [7:0] cmd);
      logic [31:0] e;
      // status is loaded before this command's own standby bit lands
      e = exp_st();
      acc(cmd, 8, 32'h0);
      chk(rd, e);
   endtask : rd_status
   // pins that follow the configuration and standby
   task automatic chk_pins();
      chk(32'(setup), 32'(m_cfg));
      chk({30'h0, sw2, sw1}, {30'h0, 2'(m_cfg >> 22) & {2{~m_low_power_state_flag[0]}}});
      chk({30'h0, pin2, pin1}, {30'h0, 1'(((m_cfg >> 20) & 3) == 2),
                                1'(((m_cfg >> 20) & 3) == 1)});
      chk(32'(low_power_state_flag), 32'(m_low_power_state_flag));
      chk(32'(dout_oe), 32'h0);
   endtask : chk_pins
   // one-cycle pulses on the converter event inputs
   task automatic events(input logic l, input logic c, input logic s,
                         input logic g);
      @(posedge sys_clk_in);
      ld <= l;
      clamped <= c;
      soon <= s;
      start <= g;
      @(posedge sys_clk_in);
      {ld, clamped, soon, start} <= 4'h0;
      repeat (4) @(posedge sys_clk_in);
      if (l) m_fresh = 1;
      if (l && c) m_clamp = 1;
      if (s && !l) m_fresh = 0;
      if (g && !(l && c)) m_clamp = 0;
   endtask : events
   // ==========================================================
   // watchdog: about 25 frames of at most 32 bits, with margin
   // ==========================================================
   initial begin
      #400us;
      n_errors++;
      $display("watchdog expired");
      stop_test();
   end
   // ==========================================================
   // main sequence
   // ==========================================================
   initial begin
      resetn_in = 1'b0;
      {lock, ld, clamped, soon, start} = 5'h0;
      word = 16'h0;
      m_fresh = 0;
      m_clamp = 0;
      m_low_power_state_flag = 0;
      m_lock = 0;
      m_cfg = 32'h7;
      rnd = $urandom(32'ha04e);
      repeat (12) @(posedge sys_clk_in);
      resetn_in <= 1'b1;
      repeat (8) @(posedge sys_clk_in);
      rd_status(8'h40);
      // output driver must be on while the frame is open
      fork
         acc(8'h41, 24, 32'h0);
         begin
            repeat (40) @(posedge sys_clk_in);
            chk(32'(dout_oe), 32'h1);
         end
      join
      chk(rd, 32'(m_cfg));
      chk_pins();
      $display("test reset_values done");
      // lock flag follows the synthesiser
      lock <= 1'b1;
      m_lock = 1;
      repeat (4) @(posedge sys_clk_in);
      rd_status(8'h40);
      // clamped result, then start, then the pre-update clear
      events(1'b1, 1'b1, 1'b0, 1'b0);
      rd_status(8'h40);
      events(1'b0, 1'b0, 1'b0, 1'b1);
      rd_status(8'h40);
      events(1'b0, 1'b0, 1'b1, 1'b0);
      rd_status(8'h40);
      // a fresh result cleared by reading the data word
      word <= 16'($urandom);
      events(1'b1, 1'b0, 1'b0, 1'b0);
      rd_status(8'h40);
      // result taken only while lock reads one
      acc(8'h43, 16, 32'h0);
      chk(rd, 32'(word));
      rd_status(8'h40);
      $display("test status_flags done");
      // every routing code with random other bits, back to back
      for (int code = 0; code < 4; code++) begin
         rnd = $urandom & 32'hffffff;
         rnd[21:20] = 2'(code);
         acc(8'h01, 24, rnd);
         chk_pins();
         // three outputs before trusting a result
         repeat (3) events(1'b1, 1'b0, 1'b0, 1'b0);
         acc(8'h41, 24, 32'h0);
         chk(rd, 32'(m_cfg));
      end
      $display("test config_routes done");
      // write to the status address is only a command byte
      acc(8'h00, 0, 32'h0);
      rd_status(8'h40);
      // standby opens the switches, power-up restores them
      acc(8'h01, 24, 32'hc00007);
      rd_status(8'h60);
      chk_pins();
      rd_status(8'h40);
      chk_pins();
      $display("test standby done");
      // sync loss recovery with standby set and a config written
      acc(8'h21, 24, 32'h912345);
      i_asc_host_model.ones(32);
      m_fresh = 0;
      m_clamp = 0;
      m_low_power_state_flag = 0;
      m_cfg = 32'h7;
      repeat (8) @(posedge sys_clk_in);
      chk_pins();
      rd_status(8'h40);
      $display("test resync done");
      stop_test();
   end
endmodule : tb_adc_status_config_regs
